// ---- urx_pkg.sv ----
package urx_pkg;

	// Register indices on the plain register port.
	localparam logic [2:0] ADDR_CTRL1  = 3'h0;
	localparam logic [2:0] ADDR_CTRL2  = 3'h1;
	localparam logic [2:0] ADDR_CTRL3  = 3'h2;
	localparam logic [2:0] ADDR_STAT1  = 3'h3;
	localparam logic [2:0] ADDR_DATA   = 3'h4;

	// Reset values.
	localparam logic [7:0] CTRL1_RST   = 8'h00;
	localparam logic [7:0] CTRL2_RST   = 8'h00;
	localparam logic [7:0] CTRL3_RST   = 8'h00;
	localparam logic [7:0] STAT1_RST   = 8'hC0;

	// Control register two bit positions.
	localparam int C2_TXE_IE  = 7;
	localparam int C2_TXC_IE  = 6;
	localparam int C2_RXF_IE  = 5;
	localparam int C2_IDLE_IE = 4;
	localparam int C2_TX_EN   = 3;
	localparam int C2_RX_EN   = 2;
	localparam int C2_STANDBY = 1;
	localparam int C2_BREAK   = 0;

	// Control register three bit positions.
	localparam int C3_R8      = 7;
	localparam int C3_OVR_IE  = 3;
	localparam int C3_NOI_IE  = 2;
	localparam int C3_FRM_IE  = 1;
	localparam int C3_PAR_IE  = 0;

	// Receiver timing: sixteen sample ticks to a bit.
	localparam int CLK_PERIOD_NS = 40;
	localparam logic [3:0] RT_LAST   = 4'hF;
	localparam logic [3:0] RT_S3     = 4'h3;
	localparam logic [3:0] RT_S5     = 4'h5;
	localparam logic [3:0] RT_S7     = 4'h7;
	localparam logic [3:0] RT_S8     = 4'h8;
	localparam logic [3:0] RT_S9     = 4'h9;
	localparam logic [3:0] RT_S10    = 4'hA;
	localparam logic [3:0] IDLE_SHORT = 4'hA;
	localparam logic [3:0] IDLE_LONG  = 4'hB;

	// Control register one layout, bit 7 first.
	typedef struct packed {
		logic loopback_select_bit;
		logic unit_enable_bit;
		logic tx_invert_bit;
		logic len_nine;
		logic wake_on_address;
		logic idle_count_type_bit;
		logic parity_enable_bit;
		logic parity_type_bit;
	} urx_ctrl1_t;

	// Status register one layout, bit 7 first.
	typedef struct packed {
		logic tx_empty_flag;
		logic tx_complete_flag;
		logic rx_full_flag;
		logic idle_flag;
		logic overrun_flag;
		logic noise_flag;
		logic framing_err_flag;
		logic parity_err_flag;
	} urx_stat1_t;

	typedef enum logic [1:0] {
		RX_HUNT,
		RX_START,
		RX_DATA,
		RX_STOP
	} urx_state_t;

endpackage : urx_pkg

// ---- urx_top.sv ----
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
// Operation
// - Missing stop bit sets framing error with receiver full; enable gates error request.
// - A break character also sets the framing error flag.
// - Standby bit set suppresses every receiver interrupt request.
// - Address wakeup: character with MSB one clears standby and sets full.
// - Idle wakeup: idle character clears standby, sets neither idle nor full.
// - Idle type bit picks idle counting start: after start or after stop.
// - Idle flag after 10 or 11 ones by length; enable gates request.
// - Buffer load sets receiver full and requests interrupt when enabled.
// - Character before buffer read sets overrun, keeps old, drops new.
// - Noise in start, data or stop bits sets noise flag; enable gates.
// - Parity mismatch sets parity error flag; enable gates error request.
// - Wait mode keeps unit running, blocks access, enabled request wakes.
// - Stop mode freezes unit with registers kept, resumes on exit.
// - Debug break without clear enable protects flags; pending clear completes later.
// - Unit enabled forces transmit pin output and receive pin input.
// - Loop select routes transmit output into receiver, pin disconnected.
// - Unit enable runs baud generator; clearing sets transmit flags, kills tx irq.
// - Inversion bit inverts every transmitted level.
// - Length bit picks 10-bit or 11-bit character.
// - Parity enable checks MSB parity of received characters; type one is odd.
// - Clearing wake select on an idle line may wake at once.
// - Reset clears every control bit of control register one.
module urx_top
#(
	parameter int RT_DIV = 13
)
(
	// Clock and reset.
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	// Register port.
	input  wire logic [2:0] addr_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic [7:0]      rd_data_o,
	// System modes.
	input  wire logic       wait_mode_i,
	input  wire logic       stop_mode_i,
	input  wire logic       debug_break_i,
	input  wire logic       break_clear_enable_i,
	// Transmitter side.
	input  wire logic       tx_level_i,
	input  wire logic       tx_empty_i,
	input  wire logic       tx_complete_i,
	output logic            tx_enable_o,
	output logic            send_break_o,
	output logic            rt_tick_o,
	// Pins.
	input  wire logic       rx_serial_pin_i,
	input  wire logic [1:0] port_direction_reg_i,
	output logic            tx_serial_pin_o,
	output logic            tx_dir_o,
	output logic            rx_dir_o,
	// Requests.
	output logic            rx_irq_o,
	output logic            err_irq_o,
	output logic            tx_irq_o,
	output logic            wake_o
);
	import urx_pkg::*;

	urx_ctrl1_t serial_control_one;
	logic [7:0] serial_control_two;
	logic [7:0] serial_control_three;
	urx_stat1_t serial_status_one;
	logic [7:0] serial_data_buffer;
	logic       run;
	logic       acc_ok;
	logic       flag_protect;
	logic       stat_rd;
	logic       data_rd;
	logic       clr_armed;
	logic       do_clear;
	logic [7:0] rt_div_cnt;
	logic       rt;
	logic [2:0] rx_sync;
	logic       rx_stable;
	logic       rx_in;
	logic       rx_on;
	urx_state_t state;
	logic [3:0] rt_cnt;
	logic [3:0] bit_cnt;
	logic [2:0] smp;
	logic [2:0] ones_hist;
	logic [8:0] shift;
	logic       noisy;
	logic       maj;
	logic       smp_noise;
	logic       done;
	logic       stop_ok;
	logic [8:0] word;
	logic       msb;
	logic       par_bad;
	logic [3:0] idle_cnt;
	logic       idle_arm;
	logic       idle_hit;
	logic       line_idle;
	logic       wake_clear;
	logic       standby;
	logic       accept;
	logic       rx_req;
	logic       err_req;
	logic       tx_req;

	// Stop mode halts every state change except the pin synchroniser and one-cycle pulses; wait mode only blocks access and gates the wake request.
	assign run          = ~stop_mode_i;
	assign acc_ok       = run & ~wait_mode_i;
	assign flag_protect = debug_break_i & ~break_clear_enable_i;
	assign stat_rd      = acc_ok & rd_i & (addr_i == ADDR_STAT1);
	assign data_rd      = acc_ok & rd_i & (addr_i == ADDR_DATA);
	assign do_clear     = data_rd & clr_armed & ~flag_protect;
	assign standby      = serial_control_two[C2_STANDBY];
	assign rx_on        = serial_control_one.unit_enable_bit
	                      & serial_control_two[C2_RX_EN];

	// Sample tick divider; it runs only while the unit is enabled.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rt_div_cnt <= 8'h00;
			rt         <= 1'b0;
		end
		else if (run && serial_control_one.unit_enable_bit)
		begin
			rt <= (rt_div_cnt == 8'(RT_DIV - 1));
			if (rt_div_cnt == 8'(RT_DIV - 1))
				rt_div_cnt <= 8'h00;
			else
				rt_div_cnt <= rt_div_cnt + 8'h01;
		end
		else
		begin
			rt <= 1'b0;
		end
	end

	// Pin synchroniser; a change counts once the last two stages agree.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rx_sync   <= 3'h7;
			rx_stable <= 1'b1;
		end
		else
		begin
			rx_sync <= {rx_sync[1:0], rx_serial_pin_i};
			if (rx_sync[2] == rx_sync[1])
				rx_stable <= rx_sync[2];
		end
	end

	assign rx_in = serial_control_one.loopback_select_bit
	               ? tx_serial_pin_o : rx_stable;

	// Three-sample majority and noise for the current sample set.
	assign maj       = (smp[0] & smp[1]) | (smp[0] & smp[2])
	                   | (smp[1] & smp[2]);
	assign smp_noise = ~(smp[0] == smp[1] && smp[1] == smp[2]);

	// Receiver bit engine.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state     <= RX_HUNT;
			rt_cnt    <= 4'h0;
			bit_cnt   <= 4'h0;
			smp       <= 3'h0;
			ones_hist <= 3'h0;
			shift     <= 9'h000;
			noisy     <= 1'b0;
			done      <= 1'b0;
			stop_ok   <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (run && rt && rx_on)
			begin
				rt_cnt <= rt_cnt + 4'h1;
				if (rt_cnt == RT_S3 || rt_cnt == RT_S8)
					smp[0] <= rx_in;
				if (rt_cnt == RT_S5 || rt_cnt == RT_S9)
					smp[1] <= rx_in;
				if (rt_cnt == RT_S7 || rt_cnt == RT_S10)
					smp[2] <= rx_in;
				case (state)
					RX_HUNT:
					begin
						ones_hist <= {ones_hist[1:0], rx_in};
						rt_cnt    <= 4'h1;
						if (!rx_in && ones_hist == 3'h7)
						begin
							state <= RX_START;
							noisy <= 1'b0;
						end
					end
					RX_START:
					begin
						// A start bit holding two or more ones is a false start.
						if (rt_cnt == RT_S8 && maj)
						begin
							state     <= RX_HUNT;
							ones_hist <= 3'h0;
						end
						else if (rt_cnt == RT_S8)
							noisy <= noisy | smp_noise;
						if (rt_cnt == 4'hB && (smp != 3'h0))
							noisy <= 1'b1;
						if (rt_cnt == RT_LAST)
						begin
							state   <= RX_DATA;
							bit_cnt <= 4'h0;
						end
					end
					RX_DATA:
					begin
						if (rt_cnt == 4'hB)
						begin
							noisy <= noisy | smp_noise;
							shift <= {maj, shift[8:1]};
						end
						if (rt_cnt == RT_LAST)
						begin
							bit_cnt <= bit_cnt + 4'h1;
							if (bit_cnt == (serial_control_one.len_nine
							                ? 4'h8 : 4'h7))
								state <= RX_STOP;
						end
					end
					RX_STOP:
					begin
						// Finish at RT11 so the next start edge is not missed.
						if (rt_cnt == 4'hB)
						begin
							stop_ok   <= maj;
							noisy     <= noisy | smp_noise;
							done      <= 1'b1;
							state     <= RX_HUNT;
							ones_hist <= {3{maj}};
						end
					end
					default:
						state <= RX_HUNT;
				endcase
			end
			else if (!rx_on)
			begin
				state     <= RX_HUNT;
				ones_hist <= 3'h0;
			end
		end
	end

	// Right-justify the received word by length.
	assign word    = serial_control_one.len_nine ? shift
	                 : {1'b0, shift[8:1]};
	assign msb     = serial_control_one.len_nine ? word[8] : word[7];
	assign par_bad = serial_control_one.parity_enable_bit
	                 & ((^word) ^ serial_control_one.parity_type_bit);
	assign accept  = done && (!standby
	                 || (serial_control_one.wake_on_address && msb));

	// Idle counter in bit times; counting restarts on any zero.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			idle_cnt  <= 4'h0;
			idle_arm  <= 1'b0;
			idle_hit  <= 1'b0;
			line_idle <= 1'b0;
		end
		else
		begin
			idle_hit <= 1'b0;
			if (run && rt && rx_on)
			begin
				if (state == RX_HUNT && !rx_in)
				begin
					idle_cnt  <= 4'h0;
					line_idle <= 1'b0;
				end
				else if (state == RX_START && rt_cnt == RT_LAST)
				begin
					idle_cnt <= 4'h0;
					idle_arm <= 1'b1;
				end
				else if (state == RX_DATA && rt_cnt == 4'hB
				         && !serial_control_one.idle_count_type_bit)
				begin
					idle_cnt <= maj ? idle_cnt + 4'h1 : 4'h0;
				end
				else if (state == RX_STOP && rt_cnt == 4'hB)
				begin
					if (!maj)
						idle_cnt <= 4'h0;
					else if (!serial_control_one.idle_count_type_bit)
						idle_cnt <= idle_cnt + 4'h1;
				end
				if (state == RX_HUNT && rx_in && rt_cnt == 4'h1
				    && bit_tick(idle_cnt))
				begin
					// Ten or eleven ones depending on the length bit.
					// The flag rises on the bit that completes the count.
					if ((idle_cnt + 4'h1) == (serial_control_one.len_nine
					                 ? IDLE_LONG : IDLE_SHORT))
					begin
						line_idle <= 1'b1;
						idle_hit  <= idle_arm;
						idle_arm  <= 1'b0;
					end
					else
						idle_cnt <= idle_cnt + 4'h1;
				end
			end
		end
	end

	// Paces hunt-state counting to one step every sixteen ticks.
	logic [3:0] hunt_rt;
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			hunt_rt <= 4'h0;
		else if (run && rt && rx_on)
			hunt_rt <= (state == RX_HUNT) ? hunt_rt + 4'h1 : 4'h0;
	end

	function automatic logic bit_tick(input logic [3:0] cnt);
		bit_tick = (hunt_rt == RT_LAST) && (cnt <= IDLE_LONG);
	endfunction : bit_tick

	// Idle wakeup, including an idle line when address wakeup is dropped.
	assign wake_clear = standby
	                    && ((!serial_control_one.wake_on_address && idle_hit)
	                    || (serial_control_one.wake_on_address && line_idle
	                    && acc_ok && wr_i && addr_i == ADDR_CTRL1
	                    && !wr_data_i[3]));

	// Control register one.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			serial_control_one <= urx_ctrl1_t'(CTRL1_RST);
		else if (acc_ok && wr_i && addr_i == ADDR_CTRL1)
			serial_control_one <= urx_ctrl1_t'(wr_data_i);
	end

	// Control register two; enable bits only move while the unit is on.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			serial_control_two <= CTRL2_RST;
		else if (run)
		begin
			if (acc_ok && wr_i && addr_i == ADDR_CTRL2)
			begin
				serial_control_two <= wr_data_i;
				if (!serial_control_one.unit_enable_bit)
				begin
					serial_control_two[C2_TX_EN] <= serial_control_two[C2_TX_EN];
					serial_control_two[C2_RX_EN] <= serial_control_two[C2_RX_EN];
				end
			end
			if (wake_clear || (accept && standby))
				serial_control_two[C2_STANDBY] <= 1'b0;
		end
	end

	// Control register three and the data buffer.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			serial_control_three <= CTRL3_RST;
			serial_data_buffer   <= 8'h00;
		end
		else if (run)
		begin
			if (acc_ok && wr_i && addr_i == ADDR_CTRL3)
				serial_control_three[3:0] <= wr_data_i[3:0];
			// A full buffer keeps the old character.
			if (accept && !serial_status_one.rx_full_flag)
			begin
				serial_data_buffer         <= word[7:0];
				serial_control_three[C3_R8] <= serial_control_one.len_nine
				                               ? word[8] : word[7];
			end
		end
	end

	// Two-step clear: read status with a flag up, then read data.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			clr_armed <= 1'b0;
		else if (run && !flag_protect)
		begin
			if (stat_rd)
				clr_armed <= |serial_status_one[5:0];
			else if (data_rd)
				clr_armed <= 1'b0;
		end
	end

	// Status flags; a setting event wins over a clear in the same cycle.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			serial_status_one <= urx_stat1_t'(STAT1_RST);
		else if (run)
		begin
			serial_status_one.tx_empty_flag <= tx_empty_i
			    | ~serial_control_one.unit_enable_bit;
			serial_status_one.tx_complete_flag <= tx_complete_i
			    | ~serial_control_one.unit_enable_bit;
			if (do_clear)
				serial_status_one[5:0] <= 6'h00;
			if (accept && !serial_status_one.rx_full_flag)
			begin
				serial_status_one.rx_full_flag <= 1'b1;
				if (!stop_ok)
					serial_status_one.framing_err_flag <= 1'b1;
				if (noisy)
					serial_status_one.noise_flag <= 1'b1;
				if (par_bad)
					serial_status_one.parity_err_flag <= 1'b1;
			end
			if (accept && serial_status_one.rx_full_flag)
				serial_status_one.overrun_flag <= 1'b1;
			if (idle_hit && !wake_clear)
				serial_status_one.idle_flag <= 1'b1;
		end
	end

	// Request terms; standby silences everything from the receiver.
	assign rx_req  = ~standby & ((serial_status_one.rx_full_flag
	                 & serial_control_two[C2_RXF_IE])
	                 | (serial_status_one.idle_flag
	                 & serial_control_two[C2_IDLE_IE]));
	assign err_req = ~standby & ((serial_status_one.overrun_flag
	                 & serial_control_three[C3_OVR_IE])
	                 | (serial_status_one.noise_flag
	                 & serial_control_three[C3_NOI_IE])
	                 | (serial_status_one.framing_err_flag
	                 & serial_control_three[C3_FRM_IE])
	                 | (serial_status_one.parity_err_flag
	                 & serial_control_three[C3_PAR_IE]));
	assign tx_req  = serial_control_one.unit_enable_bit
	                 & ((serial_status_one.tx_empty_flag
	                 & serial_control_two[C2_TXE_IE])
	                 | (serial_status_one.tx_complete_flag
	                 & serial_control_two[C2_TXC_IE]));

	// Registered outputs: pins, requests and read data.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			tx_serial_pin_o <= 1'b1;
			tx_dir_o        <= 1'b0;
			rx_dir_o        <= 1'b0;
			rx_irq_o        <= 1'b0;
			err_irq_o       <= 1'b0;
			tx_irq_o        <= 1'b0;
			wake_o          <= 1'b0;
			tx_enable_o     <= 1'b0;
			send_break_o    <= 1'b0;
			rt_tick_o       <= 1'b0;
			rd_data_o       <= 8'h00;
		end
		else if (run)
		begin
			tx_serial_pin_o <= tx_level_i
			                   ^ serial_control_one.tx_invert_bit;
			tx_dir_o <= serial_control_one.unit_enable_bit
			            | port_direction_reg_i[1];
			rx_dir_o <= ~serial_control_one.unit_enable_bit
			            & port_direction_reg_i[0];
			rx_irq_o     <= rx_req;
			err_irq_o    <= err_req;
			tx_irq_o     <= tx_req;
			wake_o       <= wait_mode_i & (rx_req | err_req | tx_req);
			tx_enable_o  <= serial_control_one.unit_enable_bit
			                & serial_control_two[C2_TX_EN];
			send_break_o <= serial_control_two[C2_BREAK];
			rt_tick_o    <= rt;
			case (addr_i)
				ADDR_CTRL1: rd_data_o <= serial_control_one;
				ADDR_CTRL2: rd_data_o <= serial_control_two;
				ADDR_CTRL3: rd_data_o <= serial_control_three;
				ADDR_STAT1: rd_data_o <= serial_status_one;
				ADDR_DATA:  rd_data_o <= serial_data_buffer;
				default:    rd_data_o <= 8'h00;
			endcase
			if (!(acc_ok && rd_i))
				rd_data_o <= 8'h00;
		end
		else
		begin
			rt_tick_o <= 1'b0;
		end
	end

endmodule : urx_top

// ---- urx_assertions.sv ----
`timescale 1ns/10ps
module urx_assertions
#(
	parameter int RT_DIV = 13
)
(
	// Clock and reset.
	input wire logic       clk_i,
	input wire logic       nrst_i,
	// Register port.
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rd_data_o,
	// Modes and pins.
	input wire logic       wait_mode_i,
	input wire logic       stop_mode_i,
	input wire logic       tx_level_i,
	input wire logic       tx_serial_pin_o,
	input wire logic       tx_dir_o,
	input wire logic       rx_dir_o,
	input wire logic       tx_enable_o,
	// Requests.
	input wire logic       rx_irq_o,
	input wire logic       err_irq_o,
	input wire logic       tx_irq_o,
	input wire logic       wake_o
);
	import urx_pkg::*;
	logic en_q;
	logic inv_q;
	// The checker cannot see control one, so it mirrors accepted writes.
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			en_q  <= 1'b0;
			inv_q <= 1'b0;
		end
		else if (wr_i && !wait_mode_i && !stop_mode_i && addr_i == ADDR_CTRL1)
		begin
			en_q  <= wr_data_i[6];
			inv_q <= wr_data_i[5];
		end
	end
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	a_dir_forced:
		assert property (en_q && $past(en_q) |-> tx_dir_o && !rx_dir_o)
		else $error("pin direction not forced");
	a_pin_invert:
		assert property (!$past(stop_mode_i) |->
			tx_serial_pin_o == ($past(tx_level_i) ^ $past(inv_q)))
		else $error("transmit pin polarity wrong");
	a_txirq_off:
		assert property (!en_q && !$past(en_q) |-> !tx_irq_o)
		else $error("transmit request while disabled");
	a_txen_unit:
		assert property (tx_enable_o |-> $past(en_q))
		else $error("transmitter enabled without unit");
	a_wake_wait:
		assert property (wake_o |-> $past(wait_mode_i))
		else $error("wake outside wait mode");
	a_wake_req:
		assert property (wait_mode_i && $past(wait_mode_i) &&
			(rx_irq_o || err_irq_o) |-> ##[0:2] (wake_o || !wait_mode_i))
		else $error("request did not wake");
	a_wait_read:
		assert property ($past(rd_i) && $past(wait_mode_i) |-> rd_data_o == 8'h00)
		else $error("read answered in wait mode");
	a_stop_frozen:
		assert property ($past(stop_mode_i) |-> $stable(tx_dir_o) &&
			$stable(rx_irq_o) && $stable(err_irq_o))
		else $error("state moved in stop mode");
endmodule : urx_assertions

// ---- urx_partner.sv ----
`timescale 1ns/10ps
module urx_partner
#(
	parameter int BIT_CLKS = 16
)
(
	// Clock.
	input  wire logic clk_i,
	// Serial line, idle high as a pulled-up wire.
	output logic      ser_o
);
	initial ser_o = 1'b1;
	// Start bit, payload LSB first, then the given stop level.
	task automatic send(input logic [8:0] d, input logic nine, input logic stop);
		@(posedge clk_i);
		ser_o <= 1'b0;
		repeat (BIT_CLKS) @(posedge clk_i);
		for (int i = 0; i < (nine ? 9 : 8); i++)
		begin
			ser_o <= d[i];
			repeat (BIT_CLKS) @(posedge clk_i);
		end
		ser_o <= stop;
		repeat (BIT_CLKS) @(posedge clk_i);
		ser_o <= 1'b1;
	endtask : send
endmodule : urx_partner

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
	import urx_pkg::*;
	localparam int RT_DIV = 1;
	logic       clk_i         = 1'b0;
	logic       nrst_i        = 1'b0;
	logic [2:0] addr_i        = 3'h0;
	logic [7:0] wr_data_i     = 8'h00;
	logic       wr_i          = 1'b0;
	logic       rd_i          = 1'b0;
	logic       wait_mode_i   = 1'b0;
	logic       stop_mode_i   = 1'b0;
	logic       debug_break_i = 1'b0;
	logic       loop_on       = 1'b0;
	logic       tx_lvl        = 1'b1;
	logic [1:0] pdir          = 2'h1;
	logic       ser;
	wire        tx_level_i    = loop_on ? ser : tx_lvl;
	// Held low in loop mode, so any leak from the pin shows up.
	wire        rx_pin        = loop_on ? 1'b0 : ser;
	logic [7:0] rd_data_o;
	logic       tx_serial_pin_o;
	logic       tx_dir_o;
	logic       rx_dir_o;
	logic       rx_irq_o;
	logic       err_irq_o;
	logic       tx_irq_o;
	logic       wake_o;
	logic [7:0] v;
	int         err_count     = 0;
	int         tests_run     = 0;

	always #20 clk_i = ~clk_i;

	urx_top #(.RT_DIV(RT_DIV)) dut_u
	(
		.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
		.rd_data_o(rd_data_o), .wait_mode_i(wait_mode_i),
		.stop_mode_i(stop_mode_i), .debug_break_i(debug_break_i),
		.break_clear_enable_i(1'b0), .tx_level_i(tx_level_i),
		.tx_empty_i(1'b1), .tx_complete_i(1'b1), .tx_enable_o(),
		.send_break_o(), .rt_tick_o(), .rx_serial_pin_i(rx_pin),
		.port_direction_reg_i(pdir), .tx_serial_pin_o(tx_serial_pin_o),
		.tx_dir_o(tx_dir_o), .rx_dir_o(rx_dir_o), .rx_irq_o(rx_irq_o),
		.err_irq_o(err_irq_o), .tx_irq_o(tx_irq_o), .wake_o(wake_o)
	);

	urx_partner #(.BIT_CLKS(16 * RT_DIV)) partner_u
	(
		.clk_i(clk_i),
		.ser_o(ser)
	);

	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i    <= a;
		wr_data_i <= d;
		wr_i      <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		d = rd_data_o;
	endtask : rd

	task automatic rc(input logic [2:0] a, input logic [7:0] e, input string n);
		rd(a, v);
		chk(n, v, e);
	endtask : rc

	// The idle flag is masked; its timing is checked on its own.
	task automatic st(input logic [7:0] e);
		rd(ADDR_STAT1, v);
		chk("status", v & 8'hEF, e);
	endtask : st

	task automatic wait_rx();
		for (int i = 0; i < 400 && rx_irq_o !== 1'b1; i++)
		begin
			@(posedge clk_i);
			#1;
		end
		chk("rx request", {7'h00, rx_irq_o}, 8'h01);
	endtask : wait_rx

	task automatic t_reset();
		rc(ADDR_CTRL1, 8'h00, "ctrl1");
		rc(ADDR_STAT1, 8'hC0, "status");
		rc(ADDR_CTRL2, 8'h00, "ctrl2");
		rc(3'h7, 8'h00, "unmapped");
	endtask : t_reset

	task automatic t_rx_basic();
		partner_u.send(9'h0A5, 1'b0, 1'b1);
		wait_rx();
		wait_mode_i <= 1'b1;
		rc(ADDR_STAT1, 8'h00, "wait read");
		chk("wake", {7'h00, wake_o}, 8'h01);
		wait_mode_i   <= 1'b0;
		debug_break_i <= 1'b1;
		rd(ADDR_STAT1, v);
		rc(ADDR_DATA, 8'hA5, "data");
		debug_break_i <= 1'b0;
		st(8'hE0);
		rc(ADDR_CTRL3, 8'h8F, "ninth bit");
		rc(ADDR_DATA, 8'hA5, "data");
		st(8'hC0);
		chk("rx request", {7'h00, rx_irq_o}, 8'h00);
	endtask : t_rx_basic

	task automatic t_errors();
		logic [7:0] c1 [4] = '{8'h40, 8'h42, 8'h43, 8'h40};
		logic [7:0] d [4]  = '{8'h11, 8'h01, 8'h01, 8'h00};
		logic       sb [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
		logic [7:0] ex [4] = '{8'h22, 8'h21, 8'h20, 8'h22};
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_CTRL1, c1[i]);
			partner_u.send({1'b0, d[i]}, 1'b0, sb[i]);
			wait_rx();
			chk("err", {7'h00, err_irq_o}, {7'h00, |ex[i][3:0]});
			st(8'hC0 | ex[i]);
			rc(ADDR_DATA, d[i], "data");
		end
		repeat (2) @(posedge clk_i);
		chk("err", {7'h00, err_irq_o}, 8'h00);
	endtask : t_errors

	task automatic t_overrun();
		partner_u.send(9'h011, 1'b0, 1'b1);
		partner_u.send(9'h022, 1'b0, 1'b1);
		repeat (3) @(posedge clk_i);
		chk("err", {7'h00, err_irq_o}, 8'h01);
		st(8'hE8);
		rc(ADDR_DATA, 8'h11, "old data");
	endtask : t_overrun

	task automatic t_standby();
		wr(ADDR_CTRL1, 8'h48);
		wr(ADDR_CTRL2, 8'h2E);
		partner_u.send(9'h005, 1'b0, 1'b1);
		repeat (4) @(posedge clk_i);
		chk("rx request", {7'h00, rx_irq_o}, 8'h00);
		rc(ADDR_CTRL2, 8'h2E, "ctrl2");
		partner_u.send(9'h085, 1'b0, 1'b1);
		wait_rx();
		rc(ADDR_CTRL2, 8'h2C, "ctrl2");
		st(8'hE0);
		rc(ADDR_DATA, 8'h85, "address");
		wr(ADDR_CTRL2, 8'h2E);
		// Long enough for eleven idle bit times on the line.
		repeat (200) @(posedge clk_i);
		wr(ADDR_CTRL1, 8'h44);
		repeat (4) @(posedge clk_i);
		rc(ADDR_CTRL2, 8'h2C, "ctrl2");
		rd(ADDR_STAT1, v);
		rd(ADDR_DATA, v);
		wr(ADDR_CTRL2, 8'h3C);
		partner_u.send(9'h055, 1'b0, 1'b1);
		wait_rx();
		rd(ADDR_STAT1, v);
		rc(ADDR_DATA, 8'h55, "data");
		repeat (3) @(posedge clk_i);
		chk("rx request", {7'h00, rx_irq_o}, 8'h00);
		wait_rx();
		rc(ADDR_STAT1, 8'hD0, "idle");
	endtask : t_standby

	task automatic t_loop();
		wr(ADDR_CTRL1, 8'hC0);
		wr(ADDR_CTRL2, 8'h2C);
		rd(ADDR_STAT1, v);
		rd(ADDR_DATA, v);
		loop_on <= 1'b1;
		partner_u.send(9'h03C, 1'b0, 1'b1);
		wait_rx();
		st(8'hE0);
		rc(ADDR_DATA, 8'h3C, "loop data");
		loop_on <= 1'b0;
	endtask : t_loop

	task automatic t_pins();
		wr(ADDR_CTRL1, 8'h60);
		wr(ADDR_CTRL2, 8'h80);
		tx_lvl <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk("pins", {5'h00, tx_serial_pin_o, tx_dir_o, rx_dir_o}, 8'h06);
		chk("tx request", {7'h00, tx_irq_o}, 8'h01);
		wr(ADDR_CTRL1, 8'h00);
		repeat (2) @(posedge clk_i);
		chk("pins", {5'h00, tx_serial_pin_o, tx_dir_o, rx_dir_o}, 8'h01);
		chk("tx request", {7'h00, tx_irq_o}, 8'h00);
		tx_lvl <= 1'b1;
	endtask : t_pins

	task automatic t_stop();
		stop_mode_i <= 1'b1;
		wr(ADDR_CTRL1, 8'h40);
		stop_mode_i <= 1'b0;
		rc(ADDR_CTRL1, 8'h00, "ctrl1");
	endtask : t_stop

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict

	initial
	begin
		#(40 * 40000);
		err_count++;
		print_verdict();
	end

	initial
	begin
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_reset();
		wr(ADDR_CTRL1, 8'h40);
		wr(ADDR_CTRL2, 8'h2C);
		wr(ADDR_CTRL3, 8'h0F);
		t_rx_basic();
		t_errors();
		t_overrun();
		t_standby();
		t_loop();
		t_pins();
		t_stop();
		print_verdict();
	end
endmodule : testbench

bind urx_top urx_assertions #(.RT_DIV(RT_DIV)) chk_u
(
	.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
	.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
	.rd_data_o(rd_data_o), .wait_mode_i(wait_mode_i),
	.stop_mode_i(stop_mode_i), .tx_level_i(tx_level_i),
	.tx_serial_pin_o(tx_serial_pin_o), .tx_dir_o(tx_dir_o),
	.rx_dir_o(rx_dir_o), .tx_enable_o(tx_enable_o),
	.rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o),
	.tx_irq_o(tx_irq_o), .wake_o(wake_o)
);
